// *** rtl/bank_sample_timing_trim_regs.sv ***
// Purpose: Wishbone register bank of per-bank sample-timing trim bytes
// Assumes: Factory trim bus is stable from reset release onward
// Notes: Bus is held off for one cycle after reset while trims load
//
// Our own choice: the Wishbone register port.
`timescale 1ns/1ps
// Behaviour
// R01 - Each trim register is one full read/write byte in bits 7 to 0.
// R02 - With the zero-degree phase selected each bank uses its phase0 trim.
// R03 - With the minus-ninety phase selected each bank uses its quadrature trim.
// R04 - After reset every trim holds its factory value, readable at once.
// R05 - A write replaces the trim, reads back as written and is applied.
// R06 - There is no fixed reset constant; reset content comes from factory trim.
// R07 - Bank k phase0 trim sits at index 0x1k2 and quadrature at the next one.
// R08 - Bank zero sits at the lowest indices 0x102 and 0x103 of the group.
// R09 - Phase select is an input and picks the byte routed to each delay output.
module bank_sample_timing_trim_regs
    import trim_pkg::*;
#(
    parameter int NUM_BANKS = NUM_BANKS_DEF
)
(
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_arst_n,
    // Wishbone slave
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [SEL_W-1:0] i_wb_sel,
    input wire logic [ADR_W-1:0] i_wb_adr,
    input wire logic [DAT_W-1:0] i_wb_dat,
    output logic o_wb_ack,
    output logic [DAT_W-1:0] o_wb_dat,
    // Factory trim and phase select
    input wire trim_pair_t [NUM_BANKS-1:0] i_factory_trim,
    input wire logic i_phase_quad,
    // Delay controls and status
    output logic [NUM_BANKS-1:0][TRIM_W-1:0] o_delay_trim,
    output logic o_trim_loaded
);

    wb_req_t req;
    bus_state_t state_reg;
    bus_state_t state_next;
    trim_pair_t [NUM_BANKS-1:0] trim_reg;
    logic [IDX_W-1:0] req_idx;
    logic [NUM_BANKS-1:0] hit_phase0;
    logic [NUM_BANKS-1:0] hit_quad;
    logic take;
    logic do_write;
    logic [DAT_W-1:0] read_next;
    logic phase_quad_sync;

    assign req = '{cyc: i_wb_cyc, stb: i_wb_stb, we: i_wb_we,
                   sel: i_wb_sel, adr: i_wb_adr, dat: i_wb_dat};
    assign req_idx = req.adr[ADR_W-1:IDX_LSB];
    assign take = (state_reg == ST_IDLE) && req.cyc && req.stb;
    assign do_write = take && req.we && req.sel[TRIM_SEL_LANE];

    // Address decode, one pair of indices per bank
    genvar k;
    generate
        for (k = 0; k < NUM_BANKS; k++)
        begin : g_dec
            localparam logic [IDX_W-1:0] P0_IDX = IDX_W'(
                BANK0_PHASE0_DELAY_TRIM_IDX + k * BANK_STRIDE); // R07 R08
            localparam logic [IDX_W-1:0] Q_IDX = IDX_W'(P0_IDX + QUAD_STEP);
            assign hit_phase0[k] = (req_idx == P0_IDX);
            assign hit_quad[k] = (req_idx == Q_IDX);
        end
    endgenerate

    // Bus sequencing; the load state keeps reads from seeing a blank trim
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            ST_LOAD: state_next = ST_IDLE;
            ST_IDLE: if (take) state_next = ST_ACK;
            ST_ACK: state_next = ST_IDLE;
            default: state_next = ST_LOAD;
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            state_reg <= ST_LOAD;
        else
            state_reg <= state_next;
    end

    // Trim storage; factory values land in the first cycle after release
    generate
        for (k = 0; k < NUM_BANKS; k++)
        begin : g_trim
            always_ff @(posedge i_sys_clk or negedge i_arst_n)
            begin
                if (!i_arst_n)
                    trim_reg[k] <= '{quadrature: TRIM_CLEAR,
                                     phase0: TRIM_CLEAR};
                else if (state_reg == ST_LOAD)
                    trim_reg[k] <= i_factory_trim[k]; // R04 R06
                else if (do_write && hit_phase0[k])
                    trim_reg[k].phase0 <= req.dat[TRIM_W-1:0]; // R01 R05
                else if (do_write && hit_quad[k])
                    trim_reg[k].quadrature <= req.dat[TRIM_W-1:0]; // R01 R05
            end
        end
    endgenerate

    // Read data; unmapped indices read as zero, upper bits always zero
    always_comb
    begin
        read_next = UNMAPPED_READ;
        for (int b = 0; b < NUM_BANKS; b++)
        begin
            if (hit_phase0[b])
                read_next = {{(DAT_W-TRIM_W){1'b0}}, trim_reg[b].phase0};
            if (hit_quad[b])
                read_next = {{(DAT_W-TRIM_W){1'b0}}, trim_reg[b].quadrature};
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_wb_ack <= 1'b0;
            o_wb_dat <= UNMAPPED_READ;
        end
        else
        begin
            o_wb_ack <= take;
            if (take && !req.we)
                o_wb_dat <= read_next; // R05
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            o_trim_loaded <= 1'b0;
        else if (state_reg == ST_LOAD)
            o_trim_loaded <= 1'b1;
    end

    // Phase select may come from another clock, so it is synchronised
    trim_sync2 u_phase_sync
    (
        .i_sys_clk(i_sys_clk),
        .i_arst_n(i_arst_n),
        .i_level(i_phase_quad),
        .o_level(phase_quad_sync)
    );

    trim_bank_select #(.NUM_BANKS(NUM_BANKS)) u_select
    (
        .i_sys_clk(i_sys_clk),
        .i_arst_n(i_arst_n),
        .i_trim(trim_reg), // R02 R03
        .i_phase_quad(phase_quad_sync), // R09
        .o_delay_trim(o_delay_trim)
    );

endmodule : bank_sample_timing_trim_regs

// *** rtl/trim_pkg.sv ***
// Purpose: Shared constants and types for the bank sample-timing trim block
// Assumes: Registers are word-indexed; byte address is four times the index
// Notes: Bank offsets follow a fixed stride from the bank 0 base
package trim_pkg;

    localparam int TRIM_W = 8;
    localparam int NUM_BANKS_DEF = 6;
    localparam int ADR_W = 12;
    localparam int DAT_W = 32;
    localparam int SEL_W = 4;
    localparam int IDX_W = 10;
    localparam int IDX_LSB = 2;

    // Register indices, four bytes apart on the bus
    localparam logic [IDX_W-1:0] BANK0_PHASE0_DELAY_TRIM_IDX = 10'h102;
    localparam logic [IDX_W-1:0] BANK0_QUADRATURE_DELAY_TRIM_IDX = 10'h103;
    localparam logic [IDX_W-1:0] BANK1_PHASE0_DELAY_TRIM_IDX = 10'h112;
    localparam logic [IDX_W-1:0] BANK1_QUADRATURE_DELAY_TRIM_IDX = 10'h113;
    localparam logic [IDX_W-1:0] BANK2_PHASE0_DELAY_TRIM_IDX = 10'h122;
    localparam logic [IDX_W-1:0] BANK2_QUADRATURE_DELAY_TRIM_IDX = 10'h123;
    localparam logic [IDX_W-1:0] BANK3_PHASE0_DELAY_TRIM_IDX = 10'h132;
    localparam logic [IDX_W-1:0] BANK3_QUADRATURE_DELAY_TRIM_IDX = 10'h133;
    localparam logic [IDX_W-1:0] BANK4_PHASE0_DELAY_TRIM_IDX = 10'h142;
    localparam logic [IDX_W-1:0] BANK4_QUADRATURE_DELAY_TRIM_IDX = 10'h143;
    localparam logic [IDX_W-1:0] BANK5_PHASE0_DELAY_TRIM_IDX = 10'h152;
    localparam logic [IDX_W-1:0] BANK5_QUADRATURE_DELAY_TRIM_IDX = 10'h153;

    localparam logic [IDX_W-1:0] BANK_STRIDE = 10'h010;
    localparam logic [IDX_W-1:0] QUAD_STEP = 10'h001;

    localparam logic [TRIM_W-1:0] TRIM_CLEAR = 8'h00;
    localparam logic [DAT_W-1:0] UNMAPPED_READ = 32'h0000_0000;
    localparam logic PHASE_SEL_RESET = 1'b0;
    localparam int TRIM_SEL_LANE = 0;

    typedef struct packed {
        logic [TRIM_W-1:0] quadrature;
        logic [TRIM_W-1:0] phase0;
    } trim_pair_t;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [SEL_W-1:0] sel;
        logic [ADR_W-1:0] adr;
        logic [DAT_W-1:0] dat;
    } wb_req_t;

    typedef enum logic [2:0]
    {
        ST_LOAD = 3'b001,
        ST_IDLE = 3'b010,
        ST_ACK = 3'b100
    } bus_state_t;

endpackage : trim_pkg

// *** rtl/trim_sync2.sv ***
// Purpose: Two-flop synchroniser for a level from another domain
// Assumes: Input is a slowly changing level
// Notes: First stage is read only by the second stage
`timescale 1ns/1ps
module trim_sync2
    import trim_pkg::*;
(
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_arst_n,
    // Level
    input wire logic i_level,
    output logic o_level
);

    logic meta_reg;

    always_ff @(posedge i_sys_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            meta_reg <= PHASE_SEL_RESET;
            o_level <= PHASE_SEL_RESET;
        end
        else
        begin
            meta_reg <= i_level;
            o_level <= meta_reg;
        end
    end

endmodule : trim_sync2

// *** rtl/trim_bank_select.sv ***
// Purpose: Per-bank choice of the trim byte that drives the delay element
// Assumes: Phase select is already synchronised
// Notes: Outputs are registered so the delay controls never glitch
`timescale 1ns/1ps
module trim_bank_select
    import trim_pkg::*;
#(
    parameter int NUM_BANKS = NUM_BANKS_DEF
)
(
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_arst_n,
    // Trim store and phase
    input wire trim_pair_t [NUM_BANKS-1:0] i_trim,
    input wire logic i_phase_quad,
    // Delay controls
    output logic [NUM_BANKS-1:0][TRIM_W-1:0] o_delay_trim
);

    genvar k;
    generate
        for (k = 0; k < NUM_BANKS; k++)
        begin : g_bank
            always_ff @(posedge i_sys_clk or negedge i_arst_n)
            begin
                if (!i_arst_n)
                    o_delay_trim[k] <= TRIM_CLEAR;
                else if (i_phase_quad)
                    o_delay_trim[k] <= i_trim[k].quadrature; // R03
                else
                    o_delay_trim[k] <= i_trim[k].phase0; // R02
            end
        end
    endgenerate

endmodule : trim_bank_select

// *** verification/trim_regs_checker.sv ***
// Purpose: Port checker for the trim bank
// Assumes: Phase held seven cycles before routing is judged
// Notes: Bound to the top module at the foot
`timescale 1ns/1ps
module trim_regs_checker
    import trim_pkg::*;
#(
    parameter int NUM_BANKS = NUM_BANKS_DEF
)
(
    input wire logic i_sys_clk,
    input wire logic i_arst_n,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [SEL_W-1:0] i_wb_sel,
    input wire logic [ADR_W-1:0] i_wb_adr,
    input wire logic [DAT_W-1:0] i_wb_dat,
    input wire logic o_wb_ack,
    input wire logic [DAT_W-1:0] o_wb_dat,
    input wire trim_pair_t [NUM_BANKS-1:0] i_factory_trim,
    input wire logic i_phase_quad,
    input wire logic [NUM_BANKS-1:0][TRIM_W-1:0] o_delay_trim,
    input wire logic o_trim_loaded
);
    logic ph_reg;
    logic [2:0] hold_reg;
    logic wr;
    assign wr = o_wb_ack && i_wb_we && i_wb_sel[0];
    // Synchroniser lag makes routing undefined just after a phase change
    always_ff @(posedge i_sys_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            ph_reg <= 1'b0;
            hold_reg <= 3'h0;
        end
        else
        begin
            ph_reg <= i_phase_quad;
            if (i_phase_quad != ph_reg)
                hold_reg <= 3'h0;
            else if (hold_reg != 3'h7)
                hold_reg <= hold_reg + 3'h1;
        end
    end
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_arst_n);
    property p_ack_pulse;
        o_wb_ack |=> !o_wb_ack;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("ack held too long");
    property p_ack_cause;
        o_wb_ack |-> $past(i_wb_cyc && i_wb_stb);
    endproperty
    a_ack_cause: assert property (p_ack_cause)
        else $error("ack without request");
    property p_no_req;
        !(i_wb_cyc && i_wb_stb) |=> !o_wb_ack;
    endproperty
    a_no_req: assert property (p_no_req)
        else $error("ack while idle");
    property p_byte_only;
        o_wb_ack && !i_wb_we |-> o_wb_dat[31:8] == 24'h0;
    endproperty
    a_byte_only: assert property (p_byte_only)
        else $error("read data above byte");
    property p_loaded_holds;
        o_trim_loaded |=> o_trim_loaded;
    endproperty
    a_loaded_holds: assert property (p_loaded_holds)
        else $error("load flag dropped");
    property p_route_p0;
        wr && !i_phase_quad && hold_reg == 3'h7 &&
        i_wb_adr[11:2] == BANK0_PHASE0_DELAY_TRIM_IDX
        |=> o_delay_trim[0] == $past(i_wb_dat[7:0]);
    endproperty
    a_route_p0: assert property (p_route_p0)
        else $error("phase0 write not applied");
    property p_route_q;
        wr && i_phase_quad && hold_reg == 3'h7 &&
        i_wb_adr[11:2] == BANK5_QUADRATURE_DELAY_TRIM_IDX
        |=> o_delay_trim[5] == $past(i_wb_dat[7:0]);
    endproperty
    a_route_q: assert property (p_route_q)
        else $error("quadrature write not applied");
    property p_out_hold;
        hold_reg == 3'h7 && !o_wb_ack |=> $stable(o_delay_trim);
    endproperty
    a_out_hold: assert property (p_out_hold)
        else $error("delay output moved");
endmodule : trim_regs_checker

bind bank_sample_timing_trim_regs trim_regs_checker #(
    .NUM_BANKS(NUM_BANKS)
) chk_u (.i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n),
    .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we),
    .i_wb_sel(i_wb_sel), .i_wb_adr(i_wb_adr), .i_wb_dat(i_wb_dat),
    .o_wb_ack(o_wb_ack), .o_wb_dat(o_wb_dat),
    .i_factory_trim(i_factory_trim), .i_phase_quad(i_phase_quad),
    .o_delay_trim(o_delay_trim), .o_trim_loaded(o_trim_loaded));

// *** verification/bank_sample_timing_trim_regs_test.sv ***
// Purpose: Register and routing test of the trim bank
// Assumes: Classic single Wishbone cycles
// Notes: Factory bytes differ per bank
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin \
    n_mismatch++; $display("CHECK FAILED %s exp %h got %h", n, e, g); \
    end end
module bank_sample_timing_trim_regs_test
    import trim_pkg::*;
;
    logic i_sys_clk = 1'b0;
    logic i_arst_n = 1'b0;
    logic quad = 1'b0;
    wb_req_t req = '0;
    trim_pair_t [NUM_BANKS_DEF-1:0] fac = '0;
    logic ack;
    logic loaded;
    logic [DAT_W-1:0] rdat;
    logic [DAT_W-1:0] rd;
    logic [NUM_BANKS_DEF-1:0][TRIM_W-1:0] dly;
    int n_mismatch = 0;
    int compares = 0;
    always #25 i_sys_clk = ~i_sys_clk;
    bank_sample_timing_trim_regs dut_u (.i_sys_clk(i_sys_clk),
        .i_arst_n(i_arst_n), .i_wb_cyc(req.cyc), .i_wb_stb(req.stb),
        .i_wb_we(req.we), .i_wb_sel(req.sel), .i_wb_adr(req.adr),
        .i_wb_dat(req.dat), .o_wb_ack(ack), .o_wb_dat(rdat),
        .i_factory_trim(fac), .i_phase_quad(quad),
        .o_delay_trim(dly), .o_trim_loaded(loaded));
    function automatic logic [7:0] fv(int k, int q);
        return q ? 8'hC4 - 8'(k * 11) : 8'h31 + 8'(k * 19);
    endfunction : fv
    function automatic logic [9:0] ix(int k, int q);
        return 10'h102 + 10'(k * 16) + 10'(q);
    endfunction : ix
    task automatic bus(input logic w, input logic [9:0] a,
        input logic [7:0] d, input logic s, output logic [31:0] q);
    begin
        req <= '{1'b1, 1'b1, w, {3'h0, s}, {a, 2'b00}, {24'h0, d}};
        do @(posedge i_sys_clk); while (ack !== 1'b1);
        q = rdat;
        req <= '0;
        @(posedge i_sys_clk);
    end
    endtask : bus
    task automatic results();
    begin
        if (n_mismatch == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    end
    endtask : results
    task automatic sweep(input logic w, input logic [7:0] x);
    begin
        for (int k = 0; k < NUM_BANKS_DEF; k++)
            for (int q = 0; q < 2; q++)
            begin
                if (w)
                    bus(1'b1, ix(k, q), fv(k, q) ^ x, 1'b1, rd);
                bus(1'b0, ix(k, q), 8'h00, 1'b1, rd);
                `CHK("trim", {24'h0, fv(k, q) ^ x}, rd)
            end
    end
    endtask : sweep
    task automatic route(input logic p, input logic [7:0] x);
    begin
        quad <= p;
        repeat (8) @(posedge i_sys_clk);
        for (int k = 0; k < NUM_BANKS_DEF; k++)
            `CHK("delay", fv(k, p) ^ x, dly[k])
    end
    endtask : route
    initial
    begin
        repeat (3000) @(posedge i_sys_clk);
        n_mismatch++;
        results();
    end
    initial
    begin
        for (int k = 0; k < NUM_BANKS_DEF; k++)
            fac[k] <= {fv(k, 1), fv(k, 0)};
        repeat (6) @(posedge i_sys_clk);
        i_arst_n <= 1'b1;
        repeat (4) @(posedge i_sys_clk);
        `CHK("loaded", 1'b1, loaded)
        sweep(1'b0, 8'h00);
        route(1'b0, 8'h00);
        route(1'b1, 8'h00);
        sweep(1'b1, 8'hFF);
        route(1'b1, 8'hFF);
        route(1'b0, 8'hFF);
        bus(1'b1, ix(0, 0), 8'h5A, 1'b1, rd);
        bus(1'b1, ix(0, 0), 8'hA5, 1'b0, rd);
        bus(1'b0, ix(0, 0), 8'h00, 1'b1, rd);
        `CHK("lane", 32'h5A, rd)
        `CHK("applied", 8'h5A, dly[0])
        bus(1'b1, 10'h101, 8'hA5, 1'b1, rd);
        bus(1'b0, 10'h101, 8'h00, 1'b1, rd);
        `CHK("unmapped", 32'h0, rd)
        // Second reset in mid-run: written trims must give way to factory
        i_arst_n <= 1'b0;
        repeat (3) @(posedge i_sys_clk);
        `CHK("reset", 1'b0, loaded)
        i_arst_n <= 1'b1;
        repeat (4) @(posedge i_sys_clk);
        `CHK("reloaded", 1'b1, loaded)
        sweep(1'b0, 8'h00);
        route(1'b0, 8'h00);
        results();
    end
endmodule : bank_sample_timing_trim_regs_test
